// file: logic/fpc_flash_protection_commit_unit.v
// The address map and the APB register port are this design's own decisions.
`default_nettype none
`include "fpc_consts.vh"
module fpc_flash_protection_commit_unit (
	input wire pclk, // System clock
	input wire presetn, // Power-on reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error
	input wire ar_valid, // Array access request
	input wire ar_fetch, // Request is an instruction fetch
	input wire [13:0] ar_addr, // Array byte address
	output reg ar_ok, // Array access allowed, one cycle
	output reg ar_fault, // Array data read refused, one cycle
	input wire [31:0] nv_word_in, // Array read word
	output reg [31:0] ar_rdata, // Returned read data, zero when refused
	output reg nv_prog, // Program pulse
	output reg nv_erase, // Page erase pulse
	output reg nv_merase, // Mass erase pulse
	output reg [13:0] nv_addr, // Array target address
	output reg [31:0] nv_data, // Array program data
	output reg dap_enable, // Debug port access enable
	output reg tap_enable, // Test access port enable
	output reg fault_irq // Access fault interrupt
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_DONE = 2'd2;
	reg [1:0] st_r;
	// Committed store: untouched by presetn, starts in the factory state
	reg [7:0] pe_nv_r;
	reg [7:0] re_nv_r;
	reg [1:0] dbg_nv_r;
	reg [7:0] pe_r;
	reg [7:0] re_r;
	reg [1:0] dbg_r;
	reg [7:0] usec_r;
	reg [13:0] addr_r;
	reg [31:0] data_r;
	reg [3:0] ctrl_r;
	reg ris_r;
	reg im_r;
	reg [7:0] tick_r;
	reg [7:0] us_r;
	reg load_r;
	// A write lands only at the edge where the access completes
	wire wr = psel & penable & pwrite & pready;
	wire key_ok = pwdata[31:16] == `FPC_KEY;
	wire [2:0] tgt_unit = addr_r[13:11];
	wire [2:0] acc_unit = ar_addr[13:11];
	wire busy = |ctrl_r;
	wire commit_go = (st_r == ST_IDLE) & ctrl_r[`FPC_CB_COMMIT];
	wire start_op = wr & (paddr == `FPC_OFS_CTRL) & key_ok & ~busy;
	wire pe_ok_tgt = pe_r[tgt_unit];
	wire mass_ok = &pe_r;
	wire blocked_pe = ctrl_r[`FPC_CB_MERASE] ? ~mass_ok : ~pe_ok_tgt;
	wire ar_data_blk = ar_valid & ~ar_fetch & ~re_r[acc_unit];
	wire pe_fault = (st_r == ST_IDLE) & (ctrl_r[`FPC_CB_WRITE] | ctrl_r[`FPC_CB_ERASE] | ctrl_r[`FPC_CB_MERASE])
		& blocked_pe;
	wire ris_set = pe_fault | ar_data_blk;
	reg [31:0] rd_nxt;
	reg hit_nxt;
	always @* begin
		rd_nxt = 32'h0000_0000;
		hit_nxt = 1'b1;
		case (paddr)
		`FPC_OFS_ADDR: rd_nxt = {18'h00000, addr_r};
		`FPC_OFS_DATA: rd_nxt = data_r;
		`FPC_OFS_CTRL: rd_nxt = {28'h0000000, ctrl_r};
		`FPC_OFS_RIS: rd_nxt = {31'h00000000, ris_r};
		`FPC_OFS_IM: rd_nxt = {31'h00000000, im_r};
		`FPC_OFS_MISC: rd_nxt = {31'h00000000, ris_r & im_r};
		`FPC_OFS_RE: rd_nxt = {dbg_r, 22'h000000, re_r};
		`FPC_OFS_PE: rd_nxt = {24'h000000, pe_r};
		`FPC_OFS_USEC: rd_nxt = {24'h000000, usec_r};
		default: hit_nxt = 1'b0;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_r <= 1'b1;
			pe_r <= `FPC_BLK_ONES;
			re_r <= `FPC_BLK_ONES;
			dbg_r <= `FPC_DBG_ON;
			usec_r <= `FPC_USEC_RST;
			addr_r <= 14'h0000;
			data_r <= 32'h0000_0000;
			ctrl_r <= 4'h0;
			ris_r <= 1'b0;
			im_r <= 1'b0;
			tick_r <= 8'h00;
			us_r <= 8'h00;
			st_r <= ST_IDLE;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ar_ok <= 1'b0;
			ar_fault <= 1'b0;
			ar_rdata <= 32'h0000_0000;
			nv_prog <= 1'b0;
			nv_erase <= 1'b0;
			nv_merase <= 1'b0;
			nv_addr <= 14'h0000;
			nv_data <= 32'h0000_0000;
			dap_enable <= 1'b0;
			tap_enable <= 1'b0;
			fault_irq <= 1'b0;
		end else begin
			pready <= psel & ~pready;
			pslverr <= psel & ~pready & ~hit_nxt;
			// Read data stands from the cycle in which pready is high
			if (psel & ~pready & ~pwrite)
				prdata <= rd_nxt;
			// First edge after reset: working bits reload from the committed store
			if (load_r) begin
				load_r <= 1'b0;
				pe_r <= pe_nv_r;
				re_r <= re_nv_r;
				dbg_r <= dbg_nv_r;
				dap_enable <= dbg_nv_r == `FPC_DBG_ON;
			end
			if (wr) begin
				case (paddr)
				`FPC_OFS_ADDR: addr_r <= pwdata[13:0];
				`FPC_OFS_DATA: data_r <= pwdata;
				`FPC_OFS_CTRL: if (start_op) ctrl_r <= pwdata[3:0];
				`FPC_OFS_IM: im_r <= pwdata[0];
				`FPC_OFS_RE: begin
					re_r <= re_r & pwdata[7:0];
					dbg_r <= dbg_r & pwdata[31:30];
				end
				`FPC_OFS_PE: pe_r <= pe_r & pwdata[7:0];
				`FPC_OFS_USEC: usec_r <= pwdata[7:0];
				default: ;
				endcase
			end
			// Set wins over the write-one clear
			ris_r <= ris_set | (ris_r & ~(wr & (paddr == `FPC_OFS_MISC) & pwdata[0]));
			fault_irq <= (ris_set | ris_r) & im_r;
			// Microsecond tick divider
			if (st_r == ST_RUN) begin
				if (tick_r == usec_r) begin
					tick_r <= 8'h00;
					us_r <= us_r + 8'h01;
				end else
					tick_r <= tick_r + 8'h01;
			end
			nv_prog <= 1'b0;
			nv_erase <= 1'b0;
			nv_merase <= 1'b0;
			case (st_r)
			ST_IDLE: begin
				tick_r <= 8'h00;
				us_r <= 8'h00;
				if (commit_go)
					st_r <= ST_DONE;
				else if (busy) begin
					if (blocked_pe)
						st_r <= ST_DONE;
					else begin
						nv_addr <= ctrl_r[`FPC_CB_WRITE] ? addr_r : {addr_r[13:10], 10'h000};
						nv_data <= data_r;
						st_r <= ST_RUN;
					end
				end
			end
			ST_RUN: begin
				nv_prog <= ctrl_r[`FPC_CB_WRITE];
				nv_erase <= ctrl_r[`FPC_CB_ERASE];
				nv_merase <= ctrl_r[`FPC_CB_MERASE];
				if (us_r == `FPC_PULSE_US)
					st_r <= ST_DONE;
			end
			ST_DONE: begin
				ctrl_r <= 4'h0;
				st_r <= ST_IDLE;
			end
			default: st_r <= ST_IDLE;
			endcase
			// Array access policy
			ar_ok <= ar_valid & ~ar_data_blk;
			ar_fault <= ar_data_blk;
			ar_rdata <= ar_data_blk ? 32'h0000_0000 : nv_word_in;
			tap_enable <= 1'b1;
		end
	end
	initial begin
		pe_nv_r = `FPC_BLK_ONES;
		re_nv_r = `FPC_BLK_ONES;
		dbg_nv_r = `FPC_DBG_ON;
	end
	// Commit writes the store; presetn does not clear it
	always @(posedge pclk) begin
		if (commit_go) begin
			if (addr_r == `FPC_DBG_COMMIT_ADDR) begin
				dbg_nv_r <= dbg_nv_r & dbg_r;
				re_nv_r <= re_nv_r & re_r;
			end else if (addr_r[0])
				pe_nv_r <= pe_nv_r & pe_r;
			else
				re_nv_r <= re_nv_r & re_r;
		end
	end
endmodule
`default_nettype wire

// file: logic/fpc_consts.vh
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
`define FPC_OFS_ADDR 12'h000
`define FPC_OFS_DATA 12'h004
`define FPC_OFS_CTRL 12'h008
`define FPC_OFS_RIS 12'h00c
`define FPC_OFS_IM 12'h010
`define FPC_OFS_MISC 12'h014
`define FPC_OFS_RE 12'h130
`define FPC_OFS_PE 12'h134
`define FPC_OFS_USEC 12'h140
`define FPC_KEY 16'ha442
`define FPC_DBG_ON 2'h2
`define FPC_DBG_OFF 2'h0
`define FPC_DBG_COMMIT_ADDR 14'h0900
`define FPC_USEC_RST 8'h18
`define FPC_BLK_ONES 8'hff
`define FPC_CB_WRITE 0
`define FPC_CB_ERASE 1
`define FPC_CB_MERASE 2
`define FPC_CB_COMMIT 3
`define FPC_PULSE_US 8'h04
`define FPC_ADDR_W 14
`endif

// file: testbench/fpc_chk_sva.sv
`default_nettype none
module fpc_chk (
	input wire logic pclk, presetn, ar_valid, ar_fetch, ar_ok, ar_fault, nv_prog, nv_erase, nv_merase,
	input wire logic dap_enable, tap_enable,
	input wire logic [31:0] ar_rdata,
	input wire logic [13:0] nv_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	zero_data_a: assert property (ar_fault |-> ar_rdata == 32'h0) else $error("refused data");
	fetch_ok_a: assert property (ar_valid && ar_fetch |=> ar_ok && !ar_fault) else $error("fetch");
	result_cause_a: assert property (ar_ok || ar_fault |-> $past(ar_valid)) else $error("cause");
	ok_fault_a: assert property (!(ar_ok && ar_fault)) else $error("both");
	one_pulse_a: assert property ($onehot0({nv_prog, nv_erase, nv_merase})) else $error("pulses");
	prog_addr_a: assert property (nv_prog && $past(nv_prog) |-> $stable(nv_addr)) else $error("addr");
	tap_on_a: assert property ($past(presetn) |-> tap_enable) else $error("tap");
	dap_hold_a: assert property ($past(presetn, 2) |-> $stable(dap_enable)) else $error("dap");
endmodule
bind fpc_flash_protection_commit_unit fpc_chk u_fpc_chk (.pclk(pclk), .presetn(presetn), .ar_valid(ar_valid),
	.ar_fetch(ar_fetch), .ar_ok(ar_ok), .ar_fault(ar_fault), .nv_prog(nv_prog), .nv_erase(nv_erase),
	.nv_merase(nv_merase), .dap_enable(dap_enable), .tap_enable(tap_enable), .ar_rdata(ar_rdata), .nv_addr(nv_addr));
`default_nettype wire

// file: testbench/fpc_array_model.sv
`default_nettype none
module fpc_array_model (
	input wire logic pclk, nv_prog, nv_erase, nv_merase, // Array pulses
	input wire logic [13:0] ar_addr, nv_addr, // Read and target address
	input wire logic [31:0] nv_data, // Program data
	output logic [31:0] nv_word_in // Read word
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [4096];
	logic pp = 1'b0;
	logic pe = 1'b0;
	logic pm = 1'b0;
	assign nv_word_in = mem[ar_addr[13:2]];
	initial foreach (mem[i]) mem[i] = 32'hffffffff;
	always @(posedge pclk) begin
		if (nv_prog && !pp) mem[nv_addr[13:2]] <= mem[nv_addr[13:2]] & nv_data;
		if (nv_erase && !pe) for (int i = 0; i < 256; i++) mem[{nv_addr[13:10], i[7:0]}] <= 32'hffffffff;
		if (nv_merase && !pm) foreach (mem[i]) mem[i] <= 32'hffffffff;
		{pp, pe, pm} <= {nv_prog, nv_erase, nv_merase};
	end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
`include "fpc_consts.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, ar_valid, ar_fetch, pready, pslverr, ar_ok, ar_fault, se;
	logic nv_prog, nv_erase, nv_merase, dap_enable, tap_enable, fault_irq;
	logic [11:0] paddr;
	logic [13:0] ar_addr, nv_addr;
	logic [31:0] pwdata, prdata, ar_rdata, nv_word_in, nv_data, r, d;
	logic [32:0] exq [$];
	int num_errors = 0;
	int samples_checked = 0;
	fpc_flash_protection_commit_unit u_fpc_flash_protection_commit_unit (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ar_valid(ar_valid), .ar_fetch(ar_fetch), .ar_addr(ar_addr),
		.ar_ok(ar_ok), .ar_fault(ar_fault), .nv_word_in(nv_word_in), .ar_rdata(ar_rdata), .nv_prog(nv_prog),
		.nv_erase(nv_erase), .nv_merase(nv_merase), .nv_addr(nv_addr), .nv_data(nv_data),
		.dap_enable(dap_enable), .tap_enable(tap_enable), .fault_irq(fault_irq));
	fpc_array_model u_fpc_array_model (.pclk(pclk), .nv_prog(nv_prog), .nv_erase(nv_erase), .nv_merase(nv_merase),
		.ar_addr(ar_addr), .nv_addr(nv_addr), .nv_data(nv_data), .nv_word_in(nv_word_in));
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	task automatic cmp(input logic [32:0] g, e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		se = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic acc(input logic f, input logic [13:0] a, input logic [32:0] e);
		@(posedge pclk);
		{ar_valid, ar_fetch, ar_addr} <= {1'b1, f, a};
		exq.push_back(e);
		@(posedge pclk);
		ar_valid <= 0;
	endtask
	// Start an array operation and poll until its control bit drops
	task automatic op(input logic [31:0] c, input int b);
		apb(1, `FPC_OFS_CTRL, c);
		repeat (300) begin
			apb(0, `FPC_OFS_CTRL, 0);
			if (r[b] === 1'b0) break;
		end
		cmp(r[b], 0);
	endtask
	always @(posedge pclk) if (ar_ok === 1'b1 || ar_fault === 1'b1) cmp({ar_fault, ar_rdata}, exq.pop_front());
	task report_and_stop;
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#2000000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		{presetn, psel, penable, pwrite, ar_valid, ar_fetch, paddr, pwdata, ar_addr} = 0;
		void'($urandom(75138));
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, `FPC_OFS_RE, 0);
		cmp(r, 32'h800000ff);
		apb(0, `FPC_OFS_PE, 0);
		cmp(r, 32'hff);
		apb(0, `FPC_OFS_USEC, 0);
		cmp(r, 32'h18);
		apb(0, 12'h020, 0);
		cmp(se, 1);
		cmp(dap_enable, 1);
		repeat (4) acc(1'($urandom), 14'($urandom) & 14'h3ffc, 33'h0ffffffff);
		apb(1, `FPC_OFS_RE, 32'h800000fb);
		acc(0, 14'h1000 | (14'($urandom) & 14'h07fc), 33'h100000000);
		acc(1, 14'h1004, 33'h0ffffffff);
		apb(1, `FPC_OFS_PE, 32'hfd);
		apb(1, `FPC_OFS_IM, 32'hffffffff);
		apb(1, `FPC_OFS_USEC, 32'h13);
		apb(1, `FPC_OFS_ADDR, 32'h800);
		op(32'ha4420001, 0);
		cmp(fault_irq, 1);
		acc(0, 14'h0800, 33'h0ffffffff);
		d = $urandom;
		apb(1, `FPC_OFS_DATA, d);
		foreach (exq[i]) @(posedge pclk);
		for (int a = 4; a < 14'h3004; a += 14'h2ffc) begin
			apb(1, `FPC_OFS_ADDR, a);
			op(32'ha4420001, 0);
			acc(0, 14'(a), {1'b0, d});
		end
		apb(1, `FPC_OFS_ADDR, 0);
		op(32'ha4420002, 1);
		acc(0, 14'h0004, 33'h0ffffffff);
		acc(0, 14'h3000, {1'b0, d});
		op(32'ha4420004, 2);
		acc(0, 14'h3000, {1'b0, d});
		apb(1, `FPC_OFS_RE, 32'hfb);
		apb(1, `FPC_OFS_ADDR, 32'h900);
		op(32'ha4420008, 3);
		cmp(dap_enable, 1);
		presetn <= 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(1, `FPC_OFS_RE, 32'hffffffff);
		apb(0, `FPC_OFS_RE, 0);
		cmp(r, 32'hfb);
		apb(0, `FPC_OFS_PE, 0);
		cmp(r, 32'hff);
		cmp({dap_enable, tap_enable}, 1);
		apb(1, `FPC_OFS_USEC, 32'h13);
		op(32'ha4420004, 2);
		acc(0, 14'h3000, 33'h0ffffffff);
		apb(1, `FPC_OFS_PE, 32'h7f);
		apb(1, `FPC_OFS_ADDR, 32'h1);
		op(32'ha4420008, 3);
		apb(0, `FPC_OFS_PE, 0);
		cmp(r, 32'h7f);
		report_and_stop();
	end
endmodule
`default_nettype wire
